/* src/dcu_pkg.sv */
package dcu_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] OFF_DATA   = 8'h00;
   localparam logic [7:0] OFF_IEN    = 8'h04;
   localparam logic [7:0] OFF_IDENT  = 8'h08;
   localparam logic [7:0] OFF_LCTL   = 8'h0C;
   localparam logic [7:0] OFF_LSTAT  = 8'h14;
   localparam logic [7:0] OFF_TCLK   = 8'h30;
   localparam logic [7:0] OFF_TIRQ   = 8'h3C;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int LCTL_DIV_SEL   = 7;
   localparam int LCTL_BREAK     = 6;
   localparam int IEN_LSTAT      = 2;
   localparam int IEN_TXE        = 1;
   localparam int IEN_RXR        = 0;
   localparam int TCLK_BAUD      = 4;

   // ****************************************
   // Reset values and fixed codes
   // ****************************************
   localparam logic [7:0] LCTL_FIXED   = 8'h03;
   localparam logic [3:0] IDENT_NONE   = 4'h1;
   localparam logic [3:0] IDENT_LSTAT  = 4'h6;
   localparam logic [3:0] IDENT_RXR    = 4'h4;
   localparam logic [3:0] IDENT_TXE    = 4'h2;
   localparam logic [3:0] OVERSAMPLE   = 4'hF;
   localparam logic [3:0] MID_SAMPLE   = 4'h7;
   localparam logic [3:0] DATA_BITS    = 4'h8;
endpackage

/* src/dcu_baud_gen.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Sixteen-times bit rate tick generator
// ****************************************
module dcu_baud_gen (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [15:0] baud_divisor,
   output logic             tick,
   output logic             bit_rate_clock_out
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        tick;
      logic        lvl;
   } dcu_bg_s;

   dcu_bg_s st_reg;
   dcu_bg_s st_next;

   // Count down divisor; zero divisor stops ticks
   always_comb begin
      st_next      = st_reg;
      st_next.tick = 1'b0;
      if (baud_divisor == 16'h0000) begin
         st_next.cnt = 16'h0000;
         st_next.lvl = 1'b0;
      end else if (st_reg.cnt <= 16'h0001) begin
         st_next.cnt  = baud_divisor;
         st_next.tick = 1'b1;
         st_next.lvl  = ~st_reg.lvl;
      end else begin
         st_next.cnt = st_reg.cnt - 16'h0001;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick               = st_reg.tick;
   assign bit_rate_clock_out = st_reg.lvl;
endmodule
`default_nettype wire

/* src/dcu_uart.sv */
// How it works
// - Bit clock is source clock over divisor, then over sixteen.
// - Divisor access bit set maps divisor low at 0x00, high at 0x04.
// - Divisor access bit clear makes 0x04 the interrupt enable register.
// - Enable bits: 2 line status, 1 transmit empty, 0 receive ready.
// - Identifier shows highest pending source: 6, 4, 2, else 1.
// - Overrun, framing or break raise line status; status read clears.
// - Received byte raises receive ready; status read clears it.
// - Identifier read showing 2 or new transmit byte clears transmit empty event.
// - Fixed eight data bits, one stop, no parity; control bits 5 to 0 read 0x03.
// - Holding empty bit set only when byte leaves holding register.
// - Bit rate clock level readable in test status clock bit 4.
// - Interrupt line level readable in test status irq bit 0.
// - Writes to 0x08 ignored, bits 7 to 4 read zero.
// - One byte holding register each way, no FIFO.
// - New received byte overwrites unread buffered byte.
// - Any divisor 0 to 65535 accepted.
`timescale 1ns/1ns
`default_nettype none
module dcu_uart (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rx_pin,
   output logic             tx_pin,
   output logic             irq_line
);
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_START = 2'b01,
      TX_DATA  = 2'b10,
      TX_STOP  = 2'b11
   } dcu_tx_e;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } dcu_rx_e;

   typedef struct packed {
      logic [31:0] rdata;
      logic        ready;
      logic        err;
      logic [15:0] divisor;
      logic        div_sel;
      logic        brk;
      logic [2:0]  ien;
      logic [7:0]  tx_hold;
      logic        thr_full;
      logic        tx_holding_empty;
      logic        tx_ev;
      dcu_tx_e     tx_st;
      logic [7:0]  tx_shift;
      logic [3:0]  tx_sub;
      logic [3:0]  tx_bits;
      logic        tx_out;
      dcu_rx_e     rx_st;
      logic [7:0]  rx_shift;
      logic [3:0]  rx_sub;
      logic [3:0]  rx_bits;
      logic        rx_zero;
      logic [7:0]  rx_buf;
      logic        rx_valid;
      logic        overrun;
      logic        fault;
      logic        brk_seen;
      logic        irq;
      logic [1:0]  rx_sync;
   } dcu_st_s;

   dcu_st_s st_reg;
   dcu_st_s st_next;

   logic tick;
   logic baud_lvl;

   // ****************************************
   // Bit rate generator
   // ****************************************
   dcu_baud_gen u_baud (
      .pclk               (pclk),
      .presetn            (presetn),
      .baud_divisor       (st_reg.divisor),
      .tick               (tick),
      .bit_rate_clock_out (baud_lvl)
   );

   // Highest priority pending source code
   function automatic logic [3:0] ident_code(input logic ls, input logic rr, input logic te);
      logic [3:0] c;
      c = dcu_pkg::IDENT_NONE;
      if (ls) begin
         c = dcu_pkg::IDENT_LSTAT;
      end else if (rr) begin
         c = dcu_pkg::IDENT_RXR;
      end else if (te) begin
         c = dcu_pkg::IDENT_TXE;
      end
      return c;
   endfunction

   logic       ls_pend;
   logic       rr_pend;
   logic       te_pend;
   logic [3:0] cur_ident;
   logic       acc;
   logic       wr;
   logic       rd;
   logic       rx_s;
   logic       rx_done;
   logic       tx_load;
   logic [7:0] lstat;

   // Pending sources gated by enables
   assign ls_pend   = st_reg.ien[dcu_pkg::IEN_LSTAT] & (st_reg.overrun | st_reg.fault | st_reg.brk_seen);
   assign rr_pend   = st_reg.ien[dcu_pkg::IEN_RXR] & st_reg.rx_valid;
   assign te_pend   = st_reg.ien[dcu_pkg::IEN_TXE] & st_reg.tx_ev;
   assign cur_ident = ident_code(ls_pend, rr_pend, te_pend);
   assign acc       = psel & penable & ~st_reg.ready;
   assign wr        = acc & pwrite;
   assign rd        = acc & ~pwrite;
   assign rx_s      = st_reg.rx_sync[1];
   assign rx_done   = tick & (st_reg.rx_st == RX_STOP) & (st_reg.rx_sub == dcu_pkg::OVERSAMPLE);
   assign tx_load   = st_reg.thr_full & (st_reg.tx_st == TX_IDLE) & tick;
   assign lstat     = {1'b0, st_reg.tx_holding_empty & (st_reg.tx_st == TX_IDLE), st_reg.tx_holding_empty, st_reg.brk_seen,
                       st_reg.fault, 1'b0, st_reg.overrun, st_reg.rx_valid};

   // ****************************************
   // Next state logic
   // ****************************************
   always_comb begin
      st_next         = st_reg;
      st_next.ready   = 1'b0;
      st_next.err     = 1'b0;
      st_next.rx_sync = {st_reg.rx_sync[0], rx_pin};

      // Transmit shifter, one holding byte
      if (tx_load) begin
         st_next.tx_shift = st_reg.tx_hold;
         st_next.thr_full = 1'b0;
         st_next.tx_holding_empty     = 1'b1;
         st_next.tx_ev    = 1'b1;
         st_next.tx_st    = TX_START;
         st_next.tx_sub   = 4'h0;
         st_next.tx_out   = 1'b0;
      end else if (tick && st_reg.tx_st != TX_IDLE) begin
         st_next.tx_sub = st_reg.tx_sub + 4'h1;
         if (st_reg.tx_sub == dcu_pkg::OVERSAMPLE) begin
            case (st_reg.tx_st)
               TX_START: begin
                  st_next.tx_st    = TX_DATA;
                  st_next.tx_bits  = 4'h0;
                  st_next.tx_out   = st_reg.tx_shift[0];
               end
               TX_DATA: begin
                  if (st_reg.tx_bits == dcu_pkg::DATA_BITS - 4'h1) begin
                     st_next.tx_st  = TX_STOP;
                     st_next.tx_out = 1'b1;
                  end else begin
                     st_next.tx_bits  = st_reg.tx_bits + 4'h1;
                     st_next.tx_shift = {1'b0, st_reg.tx_shift[7:1]};
                     st_next.tx_out   = st_reg.tx_shift[1];
                  end
               end
               TX_STOP: begin
                  st_next.tx_st = TX_IDLE;
               end
               default: begin
                  st_next.tx_st = TX_IDLE;
               end
            endcase
         end
      end

      // Receiver, sampled at mid bit
      if (tick) begin
         case (st_reg.rx_st)
            RX_IDLE: begin
               if (!rx_s) begin
                  st_next.rx_st  = RX_START;
                  st_next.rx_sub = 4'h0;
               end
            end
            RX_START: begin
               st_next.rx_sub = st_reg.rx_sub + 4'h1;
               if (st_reg.rx_sub == dcu_pkg::MID_SAMPLE) begin
                  if (rx_s) begin
                     st_next.rx_st = RX_IDLE;
                  end else begin
                     st_next.rx_st   = RX_DATA;
                     st_next.rx_sub  = 4'h0;
                     st_next.rx_bits = 4'h0;
                     st_next.rx_zero = 1'b1;
                  end
               end
            end
            RX_DATA: begin
               st_next.rx_sub = st_reg.rx_sub + 4'h1;
               if (st_reg.rx_sub == dcu_pkg::OVERSAMPLE) begin
                  st_next.rx_shift = {rx_s, st_reg.rx_shift[7:1]};
                  st_next.rx_zero  = st_reg.rx_zero & ~rx_s;
                  st_next.rx_bits  = st_reg.rx_bits + 4'h1;
                  if (st_reg.rx_bits == dcu_pkg::DATA_BITS - 4'h1) begin
                     st_next.rx_st = RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               st_next.rx_sub = st_reg.rx_sub + 4'h1;
               if (st_reg.rx_sub == dcu_pkg::OVERSAMPLE) begin
                  st_next.rx_st    = RX_IDLE;
                  st_next.rx_buf   = st_reg.rx_shift;
                  st_next.overrun  = st_reg.overrun | st_reg.rx_valid;
                  st_next.fault    = st_reg.fault | ~rx_s;
                  st_next.brk_seen = st_reg.brk_seen | (st_reg.rx_zero & ~rx_s);
               end
            end
            default: begin
               st_next.rx_st = RX_IDLE;
            end
         endcase
      end

      // ****************************************
      // APB access
      // ****************************************
      if (acc) begin
         st_next.ready = 1'b1;
         st_next.rdata = 32'h0000_0000;
      end
      if (wr) begin
         case (paddr)
            dcu_pkg::OFF_DATA: begin
               if (st_reg.div_sel) begin
                  st_next.divisor[7:0] = pwdata[7:0];
               end else begin
                  st_next.tx_hold  = pwdata[7:0];
                  st_next.thr_full = 1'b1;
                  st_next.tx_holding_empty     = 1'b0;
                  st_next.tx_ev    = 1'b0;
               end
            end
            dcu_pkg::OFF_IEN: begin
               if (st_reg.div_sel) begin
                  st_next.divisor[15:8] = pwdata[7:0];
               end else begin
                  st_next.ien = pwdata[2:0];
               end
            end
            dcu_pkg::OFF_IDENT: begin
            end
            dcu_pkg::OFF_LCTL: begin
               st_next.div_sel = pwdata[dcu_pkg::LCTL_DIV_SEL];
               st_next.brk     = pwdata[dcu_pkg::LCTL_BREAK];
            end
            dcu_pkg::OFF_LSTAT, dcu_pkg::OFF_TCLK, dcu_pkg::OFF_TIRQ: begin
            end
            default: begin
               st_next.err = 1'b1;
            end
         endcase
      end
      if (rd) begin
         case (paddr)
            dcu_pkg::OFF_DATA: begin
               if (st_reg.div_sel) begin
                  st_next.rdata[7:0] = st_reg.divisor[7:0];
               end else begin
                  st_next.rdata[7:0] = st_reg.rx_buf;
                  if (st_next.rx_st == st_reg.rx_st || st_reg.rx_st != RX_STOP) begin
                     st_next.rx_valid = 1'b0;
                  end
               end
            end
            dcu_pkg::OFF_IEN: begin
               st_next.rdata[7:0] = st_reg.div_sel ? st_reg.divisor[15:8] : {5'h00, st_reg.ien};
            end
            dcu_pkg::OFF_IDENT: begin
               st_next.rdata[7:0] = {4'h0, cur_ident};
               if (cur_ident == dcu_pkg::IDENT_TXE && !tx_load) begin
                  st_next.tx_ev = 1'b0;
               end
            end
            dcu_pkg::OFF_LCTL: begin
               st_next.rdata[7:0] = {st_reg.div_sel, st_reg.brk, 6'h00} | dcu_pkg::LCTL_FIXED;
            end
            dcu_pkg::OFF_LSTAT: begin
               st_next.rdata[7:0] = lstat;
               // Error flags clear on read; a frame ending now loads its own flags instead
               if (rx_done) begin
                  st_next.overrun  = st_reg.rx_valid;
                  st_next.fault    = ~rx_s;
                  st_next.brk_seen = st_reg.rx_zero & ~rx_s;
               end else begin
                  st_next.overrun  = 1'b0;
                  st_next.fault    = 1'b0;
                  st_next.brk_seen = 1'b0;
                  st_next.rx_valid = 1'b0;
               end
            end
            dcu_pkg::OFF_TCLK: begin
               st_next.rdata[dcu_pkg::TCLK_BAUD] = baud_lvl;
            end
            dcu_pkg::OFF_TIRQ: begin
               st_next.rdata[0] = st_reg.irq;
            end
            default: begin
               st_next.err = 1'b1;
            end
         endcase
      end

      // Received byte sets data valid; set wins over clear
      if (tick && st_reg.rx_st == RX_STOP && st_reg.rx_sub == dcu_pkg::OVERSAMPLE) begin
         st_next.rx_valid = 1'b1;
      end

      st_next.irq = ls_pend | rr_pend | te_pend;
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg         <= '0;
         st_reg.tx_out  <= 1'b1;
         st_reg.rx_sync <= 2'b11;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_pin <= 1'b1;
      end else begin
         tx_pin <= st_next.tx_out & ~st_next.brk;
      end
   end

   assign prdata   = st_reg.rdata;
   assign pready   = st_reg.ready;
   assign pslverr  = st_reg.err;
   assign irq_line = st_reg.irq;
endmodule
`default_nettype wire

/* tb/dcu_uart_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module dcu_uart_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq_line
);
   // ****************************************
   // Read completion qualifier
   // ****************************************
   logic rd_done;
   assign rd_done = pready && psel && !pwrite;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_one_wait;
      psel && penable && !pready |=> pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("ready not one cycle after access");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
   property p_ready_cause;
      pready |-> $past(psel) && $past(penable) && psel;
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
   property p_err_pair;
      pslverr |-> pready;
   endproperty
   a_err_pair: assert property (p_err_pair) else $error("error without ready");
   property p_upper_zero;
      rd_done |-> prdata[31:8] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
   property p_lctl_fixed;
      rd_done && paddr == 8'h0C |-> prdata[5:0] == 6'h03;
   endproperty
   a_lctl_fixed: assert property (p_lctl_fixed) else $error("frame format bits wrong");
   property p_ident_rsv;
      rd_done && paddr == 8'h08 |-> prdata[7:4] == 4'h0;
   endproperty
   a_ident_rsv: assert property (p_ident_rsv) else $error("ident upper bits set");
   property p_ident_code;
      rd_done && paddr == 8'h08 |-> prdata[3:0] inside {4'h1, 4'h6, 4'h4, 4'h2};
   endproperty
   a_ident_code: assert property (p_ident_code) else $error("ident code illegal");
   property p_irq_mirror;
      rd_done && paddr == 8'h3C |-> prdata[0] == $past(irq_line);
   endproperty
   a_irq_mirror: assert property (p_irq_mirror) else $error("irq status mismatch");
endmodule
bind dcu_uart dcu_uart_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .irq_line);
`default_nettype wire

/* tb/dcu_term_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Remote terminal
// ****************************************
module dcu_term_model #(
   parameter int BIT_CYC = 32
) (
   input  wire logic       pclk,
   input  wire logic       tx_pin,
   output logic            rx_pin,
   output logic [7:0]      got_byte,
   output logic            got_stb
);
   logic [8:0] sh;
   initial begin
      rx_pin = 1'b1;
      got_stb = 1'b0;
      got_byte = 8'h00;
   end
   // Start, data LSB first, stop, one idle bit
   task automatic send(input logic [7:0] b, input logic stop);
      logic [10:0] f;
      f = {1'b1, stop, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rx_pin <= f[i];
         repeat (BIT_CYC) @(posedge pclk);
      end
   endtask
   // Mid-bit capture; frames without stop dropped
   always begin
      @(negedge tx_pin);
      repeat (BIT_CYC / 2) @(negedge pclk);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT_CYC) @(negedge pclk);
         sh = {tx_pin, sh[8:1]};
      end
      if (sh[8] === 1'b1) begin
         got_byte = sh[7:0];
         got_stb = 1'b1;
         @(negedge pclk);
         got_stb = 1'b0;
      end
   end
endmodule
`default_nettype wire

/* tb/test_debug_console_uart.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
module test_debug_console_uart;
   typedef struct packed {logic w; logic e; logic [7:0] d; logic [7:0] m;} dcu_note_s;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0, b1, b2, tb;
   logic [31:0] pwdata = 0, prdata;
   logic        pready, pslverr, tx_pin, irq_line;
   wire         rx_pin, got_stb;
   wire [7:0]   got_byte;
   logic [15:0] seed = 16'h0010;
   int          err_count = 0, compares = 0;
   dcu_note_s   notes[$], nt;
   logic [7:0]  tx_q[$];

   always #2 pclk = ~pclk;
   dcu_uart DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .rx_pin, .tx_pin, .irq_line);
   dcu_term_model #(.BIT_CYC(32)) term (.pclk, .tx_pin, .rx_pin, .got_byte, .got_stb);

   task automatic print_verdict;
      if (err_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   function automatic logic [7:0] lfsr();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed[7:0];
   endfunction
   // One APB transfer, result noted for the monitor
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] m,
                      input logic e);
      int n;
      @(posedge pclk);
      notes.push_back('{w, e, d, m});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      // Hold the request until pready is sampled high at a rising edge
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n >= 50) begin
         err_count++;
         print_verdict();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 8'h00, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
      apb(1'b0, a, d, m, 1'b0);
   endtask
   task automatic wait_tx;
      int n;
      for (n = 0; n < 3000 && tx_q.size() != 0; n++) @(posedge pclk);
      if (n >= 3000) begin
         err_count++;
         print_verdict();
      end
   endtask

   // ****************************************
   // Monitors
   // ****************************************
   always @(posedge pclk) begin
      if (pready === 1'b1 && psel === 1'b1 && penable === 1'b1) begin
         if (notes.size() == 0) `CHK("note", 1'b1, 1'b0)
         else begin
            nt = notes.pop_front();
            `CHK("pslverr", nt.e, pslverr)
            if (!nt.w) `CHK("prdata", nt.d & nt.m, prdata[7:0] & nt.m)
         end
      end
   end
   always @(posedge got_stb) begin
      if (tx_q.size() == 0) `CHK("tx_q", 1'b1, 1'b0)
      else begin
         tb = tx_q.pop_front();
         `CHK("tx_byte", tb, got_byte)
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h04, 8'h00, 8'hFF);
      rd(8'h08, 8'h01, 8'hFF);
      rd(8'h0C, 8'h03, 8'hFF);
      rd(8'h14, 8'h00, 8'hFF);
      rd(8'h3C, 8'h00, 8'hFF);
      rd(8'h30, 8'h00, 8'hFF);
      apb(1'b0, 8'h10, 8'h00, 8'h00, 1'b1);
      apb(1'b1, 8'h24, 8'h00, 8'h00, 1'b1);
      wr(8'h08, 8'hFF);
      rd(8'h08, 8'h01, 8'hFF);
      wr(8'h0C, 8'h83);
      wr(8'h04, 8'hFF);
      rd(8'h04, 8'hFF, 8'hFF);
      wr(8'h04, 8'h00);
      wr(8'h00, 8'h02);
      rd(8'h00, 8'h02, 8'hFF);
      rd(8'h0C, 8'h83, 8'hFF);
      wr(8'h0C, 8'h03);
      wr(8'h04, 8'hFF);
      rd(8'h04, 8'h07, 8'hFF);
      rd(8'h30, 8'h00, 8'hEF);
      for (int k = 0; k < 3; k++) begin
         b1 = lfsr();
         b2 = lfsr();
         tx_q.push_back(b1);
         tx_q.push_back(b2);
         wr(8'h00, b1);
         wr(8'h00, b2);
         wait_tx();
         rd(8'h14, 8'h20, 8'h20);
         rd(8'h08, 8'h02, 8'h0F);
         rd(8'h08, 8'h01, 8'h0F);
      end
      b1 = lfsr();
      term.send(b1, 1'b1);
      rd(8'h08, 8'h04, 8'h0F);
      rd(8'h00, b1, 8'hFF);
      rd(8'h14, 8'h60, 8'hFF);
      b1 = lfsr();
      b2 = lfsr();
      term.send(b1, 1'b1);
      term.send(b2, 1'b1);
      rd(8'h08, 8'h06, 8'h0F);
      rd(8'h14, 8'h63, 8'hFF);
      rd(8'h08, 8'h01, 8'h0F);
      rd(8'h00, b2, 8'hFF);
      term.send(8'h00, 1'b0);
      rd(8'h08, 8'h06, 8'h0F);
      rd(8'h14, 8'h10, 8'h10);
      wr(8'h04, 8'h00);
      term.send(b1, 1'b1);
      rd(8'h3C, 8'h00, 8'h01);
      rd(8'h08, 8'h01, 8'h0F);
      wr(8'h04, 8'h01);
      rd(8'h3C, 8'h01, 8'h01);
      `CHK("irq_line", 1'b1, irq_line)
      rd(8'h00, b1, 8'hFF);
      rd(8'h3C, 8'h00, 8'h01);
      wr(8'h0C, 8'h43);
      repeat (400) @(negedge pclk);
      `CHK("tx_pin", 1'b0, tx_pin)
      wr(8'h0C, 8'h03);
      repeat (4) @(negedge pclk);
      `CHK("tx_pin", 1'b1, tx_pin)
      print_verdict();
   end
endmodule
`default_nettype wire
